// [hw/cls_logic_block.sv]
// logic block: four logic cells in two slices, combiners, carry, drivers
//
// Functional notes
// R1 - four-input table feeds cell output and storage
// R2 - four cells in two alike slices
// R3 - table usable as sixteen by one ram
// R4 - slice tables combine: 16x2, 32x1, dual-port
// R5 - table usable as sixteen-stage shift register
// R6 - storage is flip-flop or transparent latch
// R7 - storage data from table or bypass
// R8 - storage updates only with clock enable; the init and inverse forces here load it even with enable low
// R9 - init force loads configured initial value
// R10 - inverse force loads complement of initial
// R11 - forces synchronous by default, optionally asynchronous
// R12 - per-control inversion; controls shared per slice
// R13 - slice combiner selects between two tables
// R14 - block combiner selects between slice combiners
// R15 - one feedthrough path per cell
// R16 - two carry chains, two bits each
// R17 - xor for adder, and gate for multiplier
// R18 - carry path cascades tables for wide logic
// R19 - two tristate drivers, own data and enable
// R20 - carry passes to next block per chain
// R21 - ram writes on edge, reads combinationally
`timescale 1ns/1ns
`include "cls_defs.svh"

module cls_logic_block
   import cls_pkg::*;
#(
   parameter int CELLS  = `CLS_CELLS,
   parameter int SLICES = `CLS_SLICES,
   parameter int DEPTH  = `CLS_LUT_DEPTH,
   parameter int TS     = `CLS_TS_DRIVERS
) (
   input  wire logic                         clk_sys_in,
   input  wire logic                         rst_n_in,
   input  wire logic                         cfg_load_in,
   input  wire logic [CELLS-1:0][DEPTH-1:0]  lut_table_in,
   input  wire cls_cell_cfg_type [CELLS-1:0] cell_cfg_in,
   input  wire cls_slice_cfg_type [SLICES-1:0] slice_cfg_in,
   input  wire cls_cell_in_type [CELLS-1:0]  cell_in,
   input  wire logic [SLICES-1:0]            ce_in,
   input  wire logic [SLICES-1:0]            gate_in,
   input  wire logic [SLICES-1:0]            init_force_in,
   input  wire logic [SLICES-1:0]            inverse_force_in,
   input  wire logic [SLICES-1:0]            comb_sel_in,
   input  wire logic                         six_sel_in,
   input  wire logic [SLICES-1:0]            carry_in,
   input  wire logic [CELLS-1:0]             feed_in,
   input  wire logic [TS-1:0]                ts_data_in,
   input  wire logic [TS-1:0]                ts_en_in,
   output logic [CELLS-1:0]                  lut_out,
   output logic [CELLS-1:0]                  q_out,
   output logic [CELLS-1:0]                  sum_out,
   output logic [CELLS-1:0]                  tail_out,
   output logic [SLICES-1:0]                 five_input_combiner_out,
   output logic                              six_input_combiner_out,
   output logic [SLICES-1:0]                 carry_out,
   output logic [CELLS-1:0]                  feed_out,
   output logic [TS-1:0]                     ts_bus_out,
   output logic [TS-1:0]                     ts_oe_out
);

   // ==================================================================
   // helpers
   // ==================================================================
   // every slice control passes through its own inversion
   function automatic logic cls_pol(input logic v, input logic inv);
      return v ^ inv;
   endfunction : cls_pol

   // slice-level ram combining decides where each cell writes
   function automatic logic cls_from_base(input cls_ram_comb_type m,
                                          input logic odd);
      return (m == CLS_RAM_DEEP) || ((m == CLS_RAM_DUAL) && odd);
   endfunction : cls_from_base

   logic [SLICES-1:0] ce_eff;
   logic [SLICES-1:0] gate_eff;
   logic [SLICES-1:0] init_eff;
   logic [SLICES-1:0] inv_eff;

   logic [CELLS-1:0]  cin;
   logic [CELLS-1:0]  cout;
   logic [CELLS-1:0]  mux_di;
   logic [CELLS-1:0]  d_mux;
   logic [CELLS-1:0]  wr_we;
   logic [CELLS-1:0]  wr_data;
   logic [CELLS-1:0][3:0] wr_addr;
   logic [CELLS-1:0][3:0] rd_addr;

   // ==================================================================
   // shared slice controls
   // ==================================================================
   genvar s;
   generate
      for (s = 0; s < SLICES; s++) begin : g_slice
         assign ce_eff[s]   = cls_pol(ce_in[s], slice_cfg_in[s].inv_ce); // R12
         assign gate_eff[s] = cls_pol(gate_in[s], slice_cfg_in[s].inv_clk); // R12
         assign init_eff[s] = cls_pol(init_force_in[s], slice_cfg_in[s].inv_init); // R12
         assign inv_eff[s]  = cls_pol(inverse_force_in[s], slice_cfg_in[s].inv_inverse); // R12

         // in deep mode the select is the fifth address bit
         assign five_input_combiner_out[s] = comb_sel_in[s] ? lut_out[2*s+1]
                                                            : lut_out[2*s]; // R13 R4

         // chain enters at the even cell, leaves from the odd one
         assign carry_out[s] = cout[2*s+1]; // R16 R20
      end
   endgenerate

   assign six_input_combiner_out = six_sel_in ? five_input_combiner_out[1]
                                              : five_input_combiner_out[0]; // R14

   // ==================================================================
   // logic cells
   // ==================================================================
   genvar c;
   generate
      for (c = 0; c < CELLS; c++) begin : g_cell
         localparam int SL   = c / 2;
         localparam int BASE = 2 * SL;
         localparam bit ODD  = (c % 2) == 1;

         // deep ram: both tables share the base address and data,
         // the select bit steers the write to one of them
         always_comb begin
            if (cls_from_base(slice_cfg_in[SL].ram_comb, ODD)) begin
               wr_addr[c] = cell_in[BASE].addr;
               wr_data[c] = cell_in[BASE].write_data;
               wr_we[c]   = cell_in[BASE].we; // R4
            end else begin
               wr_addr[c] = cell_in[c].addr;
               wr_data[c] = cell_in[c].write_data;
               wr_we[c]   = cell_in[c].we;
            end
            if (slice_cfg_in[SL].ram_comb == CLS_RAM_DEEP) begin
               rd_addr[c] = cell_in[BASE].addr;
               wr_we[c]   = cell_in[BASE].we & (comb_sel_in[SL] == ODD); // R4
            end else begin
               rd_addr[c] = cell_in[c].addr;
            end
         end

         cls_lut #(
            .DEPTH (DEPTH),
            .AW    (`CLS_ADDR_W)
         ) u_lut (
            .clk_sys_in (clk_sys_in),
            .rst_n_in   (rst_n_in),
            .mode_in    (cell_cfg_in[c].lut_mode),
            .load_in    (cfg_load_in),
            .table_in   (lut_table_in[c]),
            .rd_addr_in (rd_addr[c]),
            .wr_addr_in (wr_addr[c]),
            .wr_data_in (wr_data[c]),
            .we_in      (wr_we[c]),
            .ce_in      (ce_eff[SL]),
            .rd_out     (lut_out[c]),
            .tail_out   (tail_out[c])
         );

         // carry: even cell takes the chain input, odd cell its neighbour
         if (ODD) begin : g_odd
            assign cin[c] = cout[c-1];
         end else begin : g_even
            assign cin[c] = carry_in[SL]; // R20
         end

         // table output is propagate; and gate gives partial products
         assign mux_di[c] = cell_cfg_in[c].and_sel ?
                            (cell_in[c].addr[0] & cell_in[c].addr[1]) // R17
                            : cell_in[c].bypass;
         assign cout[c]    = lut_out[c] ? cin[c] : mux_di[c]; // R16 R18
         assign sum_out[c] = lut_out[c] ^ cin[c]; // R17

         always_comb begin
            case (cell_cfg_in[c].d_sel)
               CLS_D_BYPASS: d_mux[c] = cell_in[c].bypass; // R7
               CLS_D_SUM:    d_mux[c] = sum_out[c];
               default:      d_mux[c] = lut_out[c]; // R1 R7
            endcase
         end

         cls_store u_store (
            .clk_sys_in    (clk_sys_in),
            .rst_n_in      (rst_n_in),
            .d_in          (d_mux[c]),
            .ce_in         (ce_eff[SL]),
            .gate_in       (gate_eff[SL]),
            .latch_mode_in (slice_cfg_in[SL].latch_mode),
            .async_in      (slice_cfg_in[SL].async_force),
            .init_val_in   (cell_cfg_in[c].init_val),
            .force_init_in (init_eff[SL]),
            .force_inv_in  (inv_eff[SL]),
            .q_out         (q_out[c])
         ); // R2 R6 R8 R9 R10 R11

         // feedthrough uses no table resource
         assign feed_out[c] = feed_in[c]; // R15
      end
   endgenerate

   // ==================================================================
   // tristate bus drivers
   // ==================================================================
   // the bus wire itself is resolved outside from the enables
   genvar t;
   generate
      for (t = 0; t < TS; t++) begin : g_ts
         assign ts_bus_out[t] = ts_data_in[t]; // R19
         assign ts_oe_out[t]  = ts_en_in[t]; // R19
      end
   endgenerate

   // ==================================================================
   // checks
   // ==================================================================
   sequence s_lower_pass;
      lut_out[0] && lut_out[1];
   endsequence

   sequence s_upper_pass;
      lut_out[2] && lut_out[3];
   endsequence

   a_carry_two_bits: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R16
      s_lower_pass |-> carry_out[0] == carry_in[0])
      else $error("carry chain did not propagate across slice");

   a_carry_upper_chain: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R20
      s_upper_pass |-> carry_out[1] == carry_in[1])
      else $error("upper carry chain did not propagate");

   a_carry_generate: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R16
      !lut_out[1] && !cell_cfg_in[1].and_sel |-> carry_out[0] == cell_in[1].bypass)
      else $error("carry generate value wrong");

   a_adder_sum: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R17
      sum_out[1] == (lut_out[1] ^ (lut_out[0] ? carry_in[0] : mux_di[0])))
      else $error("full adder sum wrong");

   a_six_selects: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R14
      six_sel_in |-> six_input_combiner_out == (comb_sel_in[1] ? lut_out[3] : lut_out[2]))
      else $error("six-input combiner picked wrong table");

   a_deep_one_side: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R4
      slice_cfg_in[0].ram_comb == CLS_RAM_DEEP |-> !(wr_we[0] && wr_we[1]))
      else $error("deep ram wrote both tables");

   a_dual_shared_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R4
      slice_cfg_in[0].ram_comb == CLS_RAM_DUAL |-> wr_addr[1] == cell_in[0].addr
                                                && rd_addr[1] == cell_in[1].addr)
      else $error("dual-port ram addressing wrong");

   a_driver_enable: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R19
      ts_oe_out == ts_en_in && (ts_bus_out & ts_en_in) == (ts_data_in & ts_en_in))
      else $error("tristate driver does not follow its own controls");

   a_force_shared: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R12
      init_eff[0] && slice_cfg_in[0].async_force |->
      q_out[1:0] == {cell_cfg_in[1].init_val, cell_cfg_in[0].init_val})
      else $error("shared async init force not seen by both cells");

endmodule : cls_logic_block

// [hw/cls_lut.sv]
// four-input lookup table with ram and shift register modes
`timescale 1ns/1ns
`include "cls_defs.svh"

module cls_lut
   import cls_pkg::*;
#(
   parameter int DEPTH = `CLS_LUT_DEPTH,
   parameter int AW    = `CLS_ADDR_W
) (
   input  wire logic             clk_sys_in,
   input  wire logic             rst_n_in,
   input  wire cls_lut_mode_type mode_in,
   input  wire logic             load_in,
   input  wire logic [DEPTH-1:0] table_in,
   input  wire logic [AW-1:0]    rd_addr_in,
   input  wire logic [AW-1:0]    wr_addr_in,
   input  wire logic             wr_data_in,
   input  wire logic             we_in,
   input  wire logic             ce_in,
   output logic                  rd_out,
   output logic                  tail_out
);

   logic [DEPTH-1:0] mem_r;

   // ==================================================================
   // table storage
   // ==================================================================
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_r <= {DEPTH{`CLS_MEM_RST}};
      end else if (load_in) begin
         mem_r <= table_in;
      end else if (ce_in) begin
         case (mode_in)
            CLS_LUT_RAM: begin
               if (we_in) begin
                  mem_r[wr_addr_in] <= wr_data_in; // R3 R21
               end
            end
            CLS_LUT_SHIFT: begin
               mem_r <= {mem_r[DEPTH-2:0], wr_data_in}; // R5
            end
            default: begin
            end
         endcase
      end
   end

   // read follows the address with no clock, in every mode
   assign rd_out   = mem_r[rd_addr_in]; // R1 R21
   assign tail_out = mem_r[DEPTH-1];

   // ==================================================================
   // checks
   // ==================================================================
   sequence s_shift_step;
      !load_in && ce_in && mode_in == CLS_LUT_SHIFT;
   endsequence

   a_ram_write_lands: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R21
      !load_in && ce_in && we_in && mode_in == CLS_LUT_RAM
      |=> mem_r[$past(wr_addr_in)] == $past(wr_data_in))
      else $error("ram write did not land");

   a_shift_two_steps: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R5
      s_shift_step ##1 s_shift_step |=> tail_out == $past(mem_r[DEPTH-3], 2))
      else $error("shift register tail wrong after two steps");

   a_logic_table_kept: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R1
      !load_in && mode_in == CLS_LUT_LOGIC |=> $stable(mem_r))
      else $error("logic table changed without load");

endmodule : cls_lut

// [hw/cls_store.sv]
// storage element: flip-flop or latch with forcing controls
`timescale 1ns/1ns
`include "cls_defs.svh"

module cls_store (
   input  wire logic clk_sys_in,
   input  wire logic rst_n_in,
   input  wire logic d_in,
   input  wire logic ce_in,
   input  wire logic gate_in,
   input  wire logic latch_mode_in,
   input  wire logic async_in,
   input  wire logic init_val_in,
   input  wire logic force_init_in,
   input  wire logic force_inv_in,
   output logic      q_out
);

   logic held_r;
   logic force_any;
   logic force_val;
   logic open_latch;

   // init force outranks inverse force when both are asserted
   assign force_any  = force_init_in | force_inv_in;
   assign force_val  = force_init_in ? init_val_in : ~init_val_in; // R9 R10
   assign open_latch = latch_mode_in & ce_in & gate_in;

   // ==================================================================
   // held value
   // ==================================================================
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         held_r <= `CLS_HELD_RST;
      end else if (force_any) begin
         held_r <= force_val; // R9 R10
      end else if (ce_in && (!latch_mode_in || gate_in)) begin
         held_r <= d_in; // R6 R8
      end
   end

   // async force overrides at once; a latch passes data while open
   always_comb begin
      if (async_in && force_any) begin
         q_out = force_val; // R11
      end else if (open_latch) begin
         q_out = d_in; // R6
      end else begin
         q_out = held_r;
      end
   end

   // ==================================================================
   // checks
   // ==================================================================
   a_init_force_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R9
      force_init_in |=> held_r == $past(init_val_in))
      else $error("init force did not load initial value");

   a_inverse_force_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
      force_inv_in && !force_init_in |=> held_r == !$past(init_val_in))
      else $error("inverse force did not load complement");

   a_hold_without_ce: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R8
      !force_any && !ce_in |=> held_r == $past(held_r))
      else $error("storage changed without clock enable");

   a_sync_force_waits: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R11
      !async_in && force_any && !open_latch |-> q_out == held_r)
      else $error("synchronous force acted before the edge");

endmodule : cls_store

// [inc/cls_defs.svh]
// constants shared by the logic block design files
`ifndef CLS_DEFS_SVH
`define CLS_DEFS_SVH

// =====================================================================
// structure
// =====================================================================
`define CLS_LUT_DEPTH   16
`define CLS_ADDR_W      4
`define CLS_CELLS       4
`define CLS_SLICES      2
`define CLS_TS_DRIVERS  2

// =====================================================================
// reset values
// =====================================================================
`define CLS_MEM_RST     1'b0
`define CLS_HELD_RST    1'b0

`endif

// [inc/cls_pkg.sv]
// types shared by the logic block design files
package cls_pkg;

   // ==================================================================
   // modes
   // ==================================================================
   typedef enum logic [1:0] {
      CLS_LUT_LOGIC = 2'b00,
      CLS_LUT_RAM   = 2'b01,
      CLS_LUT_SHIFT = 2'b10
   } cls_lut_mode_type;

   typedef enum logic [1:0] {
      CLS_D_LUT    = 2'b00,
      CLS_D_BYPASS = 2'b01,
      CLS_D_SUM    = 2'b10
   } cls_d_sel_type;

   typedef enum logic [1:0] {
      CLS_RAM_SINGLE = 2'b00,
      CLS_RAM_DEEP   = 2'b01,
      CLS_RAM_DUAL   = 2'b10
   } cls_ram_comb_type;

   // ==================================================================
   // carriers
   // ==================================================================
   typedef struct packed {
      cls_lut_mode_type lut_mode;
      cls_d_sel_type    d_sel;
      logic             and_sel;
      logic             init_val;
   } cls_cell_cfg_type;

   typedef struct packed {
      logic             latch_mode;
      logic             async_force;
      logic             inv_clk;
      logic             inv_ce;
      logic             inv_init;
      logic             inv_inverse;
      cls_ram_comb_type ram_comb;
   } cls_slice_cfg_type;

   typedef struct packed {
      logic [3:0] addr;
      logic       bypass;
      logic       write_data;
      logic       we;
   } cls_cell_in_type;

endpackage : cls_pkg

// [tb/cls_fabric_model.sv]
// fabric model: horizontal bus lines resolved from the block's drivers
`timescale 1ns/1ns

module cls_fabric_model (
   input  wire logic       clk_sys_in,
   input  wire logic [1:0] ts_bus_in,
   input  wire logic [1:0] ts_oe_in,
   output logic      [1:0] line_out
);
   logic [1:0] last_r;

   // =================================================================
   // bus lines
   // =================================================================
   // no keeper here: a released line shows the inverse of its last level
   always_ff @(posedge clk_sys_in) begin
      last_r <= line_out;
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         line_out[i] = ts_oe_in[i] ? ts_bus_in[i] : ~last_r[i];
      end
   end
endmodule : cls_fabric_model

// [tb/tb_configurable_logic_slice.sv]
// testbench for the logic block
`timescale 1ns/1ns

module tb_configurable_logic_slice;
   import cls_pkg::*;
   logic                    clk_sys_in, rst_n_in, cfg_load_in, six_sel_in, six_out;
   logic [3:0][15:0]        lut_table_in;
   cls_cell_cfg_type [3:0]  cell_cfg_in;
   cls_slice_cfg_type [1:0] slice_cfg_in;
   cls_cell_in_type [3:0]   cell_in;
   logic [1:0]              ce_in, gate_in, init_force_in, inverse_force_in, comb_sel_in;
   logic [1:0]              carry_in, ts_data_in, ts_en_in, five_out, carry_out;
   logic [1:0]              ts_bus_out, ts_oe_out, line;
   logic [3:0]              feed_in, lut_out, q_out, sum_out, tail_out, feed_out;
   int                      errors, compares;

   // =================================================================
   // instances
   // =================================================================
   cls_logic_block cls_logic_block_inst (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cfg_load_in(cfg_load_in),
      .lut_table_in(lut_table_in), .cell_cfg_in(cell_cfg_in), .slice_cfg_in(slice_cfg_in),
      .cell_in(cell_in), .ce_in(ce_in), .gate_in(gate_in), .init_force_in(init_force_in),
      .inverse_force_in(inverse_force_in), .comb_sel_in(comb_sel_in),
      .six_sel_in(six_sel_in), .carry_in(carry_in), .feed_in(feed_in),
      .ts_data_in(ts_data_in), .ts_en_in(ts_en_in), .lut_out(lut_out), .q_out(q_out),
      .sum_out(sum_out), .tail_out(tail_out), .five_input_combiner_out(five_out),
      .six_input_combiner_out(six_out), .carry_out(carry_out), .feed_out(feed_out),
      .ts_bus_out(ts_bus_out), .ts_oe_out(ts_oe_out));

   cls_fabric_model cls_fabric_model_inst (
      .clk_sys_in(clk_sys_in), .ts_bus_in(ts_bus_out), .ts_oe_in(ts_oe_out),
      .line_out(line));

   // =================================================================
   // helpers
   // =================================================================
   task automatic step();
      @(posedge clk_sys_in);
      #2;
   endtask : step

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic load(input logic [3:0][15:0] t);
      lut_table_in = t;
      cfg_load_in = 1'b1;
      step();
      cfg_load_in = 1'b0;
   endtask : load

   task automatic results();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   // =================================================================
   // scenarios
   // =================================================================
   task automatic t_logic();
      logic [3:0][15:0] t;
      logic [1:0]       f;
      t = {16'hf0f0, 16'h0ff0, 16'haaaa, 16'h5555};
      load(t);
      for (int a = 0; a < 16; a++) begin
         for (int m = 0; m < 8; m++) begin
            step();
            for (int c = 0; c < 4; c++) cell_in[c].addr = 4'(a);
            {six_sel_in, comb_sel_in} = 3'(m);
            feed_in = 4'(a);
            #1;
            f[0] = comb_sel_in[0] ? t[1][a] : t[0][a];
            f[1] = comb_sel_in[1] ? t[3][a] : t[2][a];
            chk(16'(lut_out), 16'({t[3][a], t[2][a], t[1][a], t[0][a]}), "table");
            chk(16'(five_out), 16'(f), "five combiner");
            chk(16'(six_out), 16'(six_sel_in ? f[1] : f[0]), "six combiner");
            chk(16'(feed_out), 16'(a), "feedthrough");
         end
      end
   endtask : t_logic

   task automatic t_carry();
      load({4{16'hffff}});
      for (int i = 0; i < 4; i++) begin
         carry_in = 2'(i);
         #1;
         chk(16'(carry_out), 16'(i), "carry propagate");
         chk(16'(sum_out), 16'(4'(~{{2{carry_in[1]}}, {2{carry_in[0]}}})), "sum");
         step();
      end
      load('0);
      carry_in = 2'b00;
      ce_in = 2'b11;
      for (int c = 0; c < 4; c++) begin
         cell_cfg_in[c].and_sel = 1'b1;
         cell_cfg_in[c].d_sel = CLS_D_SUM;
         cell_in[c].addr = 4'h3;
      end
      #1;
      chk(16'(carry_out), 16'h3, "and generate");
      chk(16'(sum_out), 16'ha, "cascaded carry");
      step();
      chk(16'(q_out), 16'ha, "sum capture");
      for (int c = 0; c < 4; c++) cell_in[c].addr = 4'h1;
      #1;
      chk(16'(carry_out), 16'h0, "and kill");
   endtask : t_carry

   task automatic t_ram();
      load('0);
      cell_cfg_in[0].lut_mode = CLS_LUT_RAM;
      ce_in = 2'b11;
      for (int c = 0; c < 4; c++) cell_in[c] = {4'h5, 1'b0, 1'b1, 1'b1};
      step();
      for (int c = 0; c < 4; c++) cell_in[c].we = 1'b0;
      #1;
      chk(16'(lut_out), 16'h1, "ram write, logic ignores");
      cell_in[0].addr = 4'h4;
      #1;
      chk(16'(lut_out[0]), 16'h0, "ram other word");
      ce_in = 2'b00;
      cell_in[0] = {4'h6, 1'b0, 1'b1, 1'b1};
      step();
      cell_in[0].we = 1'b0;
      #1;
      chk(16'(lut_out[0]), 16'h0, "write without enable");
      slice_cfg_in[0].ram_comb = CLS_RAM_DEEP;
      cell_cfg_in[1].lut_mode = CLS_LUT_RAM;
      ce_in = 2'b11;
      comb_sel_in = 2'b01;
      cell_in[0] = {4'h3, 1'b0, 1'b1, 1'b1};
      step();
      cell_in[0].we = 1'b0;
      #1;
      chk(16'(five_out[0]), 16'h1, "deep upper half");
      comb_sel_in = 2'b00;
      #1;
      chk(16'(five_out[0]), 16'h0, "deep lower half");
      slice_cfg_in[0].ram_comb = CLS_RAM_DUAL;
      cell_in[0] = {4'h7, 1'b0, 1'b1, 1'b1};
      cell_in[1].addr = 4'h7;
      step();
      cell_in[0].we = 1'b0;
      #1;
      chk(16'(lut_out[1:0]), 16'h3, "dual write");
      slice_cfg_in[0].ram_comb = CLS_RAM_SINGLE;
      cell_cfg_in[0].lut_mode = CLS_LUT_LOGIC;
      cell_cfg_in[1].lut_mode = CLS_LUT_LOGIC;
   endtask : t_ram

   task automatic t_shift();
      load('0);
      cell_cfg_in[2].lut_mode = CLS_LUT_SHIFT;
      ce_in = 2'b10;
      cell_in[2].write_data = 1'b1;
      step();
      cell_in[2].write_data = 1'b0;
      repeat (14) step();
      chk(16'(tail_out[2]), 16'h0, "tail after 15");
      step();
      chk(16'(tail_out[2]), 16'h1, "tail after 16");
      cell_cfg_in[2].lut_mode = CLS_LUT_LOGIC;
   endtask : t_shift

   task automatic t_store();
      for (int c = 0; c < 2; c++) begin
         cell_cfg_in[c].d_sel = CLS_D_BYPASS;
         cell_in[c].bypass = 1'b1;
      end
      cell_cfg_in[0].init_val = 1'b1;
      ce_in = 2'b01;
      step();
      chk(16'(q_out[1:0]), 16'h3, "bypass capture");
      ce_in = 2'b00;
      cell_in[0].bypass = 1'b0;
      cell_in[1].bypass = 1'b0;
      step();
      chk(16'(q_out[1:0]), 16'h3, "hold without enable");
      init_force_in = 2'b01;
      #1;
      chk(16'(q_out[1:0]), 16'h3, "sync force waits");
      step();
      chk(16'(q_out[1:0]), 16'h1, "init force");
      init_force_in = 2'b00;
      inverse_force_in = 2'b01;
      step();
      chk(16'(q_out[1:0]), 16'h2, "inverse force");
      inverse_force_in = 2'b00;
      slice_cfg_in[0].async_force = 1'b1;
      init_force_in = 2'b01;
      #1;
      chk(16'(q_out[1:0]), 16'h1, "async force");
      step();
      init_force_in = 2'b00;
      slice_cfg_in[0].async_force = 1'b0;
      slice_cfg_in[0].inv_ce = 1'b1;
      step();
      chk(16'(q_out[1:0]), 16'h0, "inverted enable");
      slice_cfg_in[0].latch_mode = 1'b1;
      gate_in = 2'b01;
      cell_in[0].bypass = 1'b1;
      cell_in[1].bypass = 1'b1;
      #1;
      chk(16'(q_out[1:0]), 16'h3, "latch transparent");
      slice_cfg_in[0] = '0;
   endtask : t_store

   task automatic t_bus();
      ts_en_in = 2'b11;
      ts_data_in = 2'b10;
      #1;
      chk(16'({ts_oe_out, ts_bus_out, line}), 16'h3a, "drivers on");
      step();
      ts_en_in = 2'b00;
      #1;
      chk(16'({ts_oe_out, line}), 16'h1, "drivers released");
   endtask : t_bus

   // =================================================================
   // clock, watchdog, sequence
   // =================================================================
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   // about 170 cycles expected; the 3000-cycle limit is a hang
   initial begin
      #60000;
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      results();
   end

   initial begin
      {rst_n_in, cfg_load_in, six_sel_in, lut_table_in, cell_cfg_in, slice_cfg_in} = '0;
      {cell_in, ce_in, gate_in, init_force_in, inverse_force_in, comb_sel_in} = '0;
      {carry_in, ts_data_in, ts_en_in, feed_in} = '0;
      repeat (6) @(posedge clk_sys_in);
      #2;
      rst_n_in = 1'b1;
      chk(16'({lut_out, q_out}), 16'h0, "after reset");
      t_logic();
      t_carry();
      t_ram();
      t_store();
      t_shift();
      t_bus();
      results();
   end
endmodule : tb_configurable_logic_slice
